// ---- design/eezl_loader.v ----
/*
 * Zone configuration loader: walks the local configuration, the
 * identification and the configuration-space zones of a serial memory
 * and writes the bytes into the device's register banks.
 * Assumes a word reader for the memory, a start pulse at the release of
 * bus reset, and an APB master for status and control.
 */
// The implementer's own choices: register access over APB and the register addresses.
`include "eezl_regs.vh"
`default_nettype none

module eezl_loader #(
   parameter ADDR_W = 10
) (
   input wire pclk,
   input wire presetn,
   input wire load_start,
   input wire mem_present,
   input wire [ADDR_W:0] mem_size,
   output wire mem_rd_req,
   output wire [ADDR_W-1:0] mem_rd_addr,
   input wire mem_rd_ack,
   input wire [15:0] mem_rd_data,
   output reg pci_retry,
   output reg [31:0] local_control_reg,
   output reg [31:0] multipurpose_io_config,
   output reg [31:0] local_bus_timing_1,
   output reg [31:0] local_bus_timing_2,
   output reg [31:0] global_interrupt_reg,
   output reg [15:0] vendor_id,
   output reg [15:0] subsys_vendor_id,
   output wire [31:0] fn_device_id,
   output wire [47:0] fn_class_code,
   output wire [31:0] fn_subsys_id,
   output wire [15:0] fn_int_pin,
   output wire [1:0] fn_ext_cap,
   output wire [31:0] fn_pm_cap,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr
);

   localparam ST_IDLE = 5'h01;
   localparam ST_LOCAL = 5'h02;
   localparam ST_IDENT = 5'h04;
   localparam ST_FHDR = 5'h08;
   localparam ST_FCFG = 5'h10;

   reg [4:0] state_reg;
   reg [4:0] ctrl_reg;
   reg done_reg;
   reg overrun_reg;
   reg nomem_reg;
   reg [2:0] func_reg;
   reg group_reg;
   reg go;
   reg [31:0] rd_mux;
   reg rd_err;
   wire word_valid;
   wire [15:0] word_data;
   wire overrun;
   wire [6:0] w_off;
   wire [7:0] w_byte;
   wire w_more;
   wire apb_wr;
   wire reload;
   wire start;
   wire cfg_wr;
   wire [2:0] start_zones;

   assign w_off = word_data[`EEZL_W_OFF_HI:`EEZL_W_OFF_LO];
   assign w_byte = word_data[7:0];
   assign w_more = word_data[`EEZL_W_MORE];
   assign apb_wr = psel && penable && pready && pwrite;
   assign reload = apb_wr && (paddr == `EEZL_OFF_CTRL) &&
                   pwdata[`EEZL_CTRL_RELOAD];
   assign start = load_start || reload;
   assign cfg_wr = word_valid && (state_reg == ST_FCFG);
   // Enables written with the reload bit apply to that very load
   assign start_zones = reload ?
                        pwdata[`EEZL_CTRL_ZONE_HI:`EEZL_CTRL_ZONE_LO] :
                        ctrl_reg[`EEZL_CTRL_ZONE_HI:`EEZL_CTRL_ZONE_LO];

   // Next present zone after the given one, in zone order
   function [4:0] zone_after;
      input [1:0] from;
      input [2:0] en;
      begin
         if (from < 2'd1 && en[0]) begin
            zone_after = ST_LOCAL;
         end else if (from < 2'd2 && en[1]) begin
            zone_after = ST_IDENT;
         end else if (en[2]) begin
            zone_after = ST_FHDR;
         end else begin
            zone_after = ST_IDLE;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   eezl_word_fetch #(
      .ADDR_W(ADDR_W)
   ) u_fetch (
      .pclk(pclk),
      .presetn(presetn),
      .restart(start),
      .go(go),
      .mem_size(mem_size),
      .mem_rd_req(mem_rd_req),
      .mem_rd_addr(mem_rd_addr),
      .mem_rd_ack(mem_rd_ack),
      .mem_rd_data(mem_rd_data),
      .word_valid(word_valid),
      .word_data(word_data),
      .overrun(overrun)
   );

   ////////////////////////////////////////////////////////////////////
   // Zone walker; each zone entered once, then left for good
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         func_reg <= 3'h0;
         group_reg <= 1'b0;
         go <= 1'b0;
         done_reg <= 1'b0;
         pci_retry <= 1'b0;
      end else begin
         go <= 1'b0;
         if (start) begin
            done_reg <= 1'b0;
            group_reg <= 1'b0;
            if (!mem_present) begin
               state_reg <= ST_IDLE;
               done_reg <= 1'b1;
               pci_retry <= 1'b0;
            end else begin
               // Absent zones take no words
               state_reg <= zone_after(2'd0, start_zones);
               go <= |start_zones;
               pci_retry <= |start_zones;
               done_reg <= ~|start_zones;
            end
         end else if (overrun) begin
            // Abort without undoing what was loaded
            state_reg <= ST_IDLE;
            pci_retry <= 1'b0;
            done_reg <= 1'b1;
         end else if (word_valid) begin
            go <= 1'b1;
            case (state_reg)
               ST_LOCAL: begin
                  if (!w_more) begin
                     state_reg <= zone_after(2'd1,
                        ctrl_reg[`EEZL_CTRL_ZONE_HI:`EEZL_CTRL_ZONE_LO]);
                  end
               end
               ST_IDENT: begin
                  if (!w_more) begin
                     state_reg <= zone_after(2'd2,
                        ctrl_reg[`EEZL_CTRL_ZONE_HI:`EEZL_CTRL_ZONE_LO]);
                  end
               end
               ST_FHDR: begin
                  if (!w_more) begin
                     state_reg <= ST_IDLE;
                  end else begin
                     func_reg <= word_data[`EEZL_FH_FN_HI:0];
                     state_reg <= ST_FCFG;
                  end
               end
               ST_FCFG: begin
                  // Second group closes the zone
                  if (!w_more) begin
                     group_reg <= 1'b1;
                     state_reg <= group_reg ? ST_IDLE : ST_FHDR;
                  end
               end
               default: begin
                  state_reg <= ST_IDLE;
               end
            endcase
            if ((state_reg == ST_FHDR && !w_more) ||
                (state_reg == ST_FCFG && !w_more && group_reg) ||
                (state_reg == ST_LOCAL && !w_more &&
                 zone_after(2'd1, ctrl_reg[4:2]) == ST_IDLE) ||
                (state_reg == ST_IDENT && !w_more &&
                 zone_after(2'd2, ctrl_reg[4:2]) == ST_IDLE)) begin
               go <= 1'b0;
               pci_retry <= 1'b0;
               done_reg <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Local configuration bank; only the listed offsets land
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         local_control_reg <= `EEZL_RST_LOCAL;
         multipurpose_io_config <= `EEZL_RST_MIO;
         local_bus_timing_1 <= `EEZL_RST_TIM1;
         local_bus_timing_2 <= `EEZL_RST_TIM2;
         global_interrupt_reg <= `EEZL_RST_GIR;
      end else if (word_valid && state_reg == ST_LOCAL) begin
         case (w_off)
            // Low two bits kept zero whatever the byte says
            `EEZL_LO_CTRL: local_control_reg[7:2] <= w_byte[7:2];
            `EEZL_LO_MULTIPURPOSE_PIN_ZERO: multipurpose_io_config[7:0] <= w_byte;
            `EEZL_LO_MIO1: multipurpose_io_config[15:8] <= w_byte;
            `EEZL_LO_MIO2: multipurpose_io_config[23:16] <= w_byte;
            `EEZL_LO_MIO3: begin
               if (ctrl_reg[`EEZL_CTRL_ENH]) begin
                  multipurpose_io_config[31:29] <= w_byte[7:5];
                  multipurpose_io_config[26] <= w_byte[2];
               end
            end
            `EEZL_LO_T1B1: local_bus_timing_1[15:8] <= w_byte;
            `EEZL_LO_T1B2: local_bus_timing_1[23:16] <= w_byte;
            `EEZL_LO_T1B3: local_bus_timing_1[31:24] <= w_byte;
            `EEZL_LO_T2B0: local_bus_timing_2[7:0] <= w_byte;
            `EEZL_LO_T2B1: local_bus_timing_2[15:8] <= w_byte;
            // Low nibble forced zero
            `EEZL_LO_T2B2: local_bus_timing_2[23:20] <= w_byte[7:4];
            `EEZL_LO_T2B3: begin
               local_bus_timing_2[26:24] <= w_byte[2:0];
               local_bus_timing_2[30] <= w_byte[6];
               local_bus_timing_2[31] <= w_byte[7];
            end
            `EEZL_LO_GIR2: global_interrupt_reg[23:16] <= w_byte;
            `EEZL_LO_GIR3: global_interrupt_reg[31:24] <= w_byte;
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Identifiers: only this zone can reach them
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vendor_id <= `EEZL_RST_VID;
         subsys_vendor_id <= `EEZL_RST_SVID;
      end else if (word_valid && state_reg == ST_IDENT) begin
         case (w_off)
            `EEZL_ID_VID_LO: vendor_id[7:0] <= w_byte;
            `EEZL_ID_VID_HI: vendor_id[15:8] <= w_byte;
            `EEZL_ID_SVID_LO: subsys_vendor_id[7:0] <= w_byte;
            `EEZL_ID_SVID_HI: subsys_vendor_id[15:8] <= w_byte;
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Per-function configuration space; reserved functions write nothing
   genvar fn;
   generate
      for (fn = 0; fn < 2; fn = fn + 1) begin : g_fn
         reg [15:0] did_reg;
         reg [23:0] cc_reg;
         reg [15:0] ssid_reg;
         reg [7:0] pin_reg;
         reg ext_reg;
         reg [15:0] pm_reg;
         wire hit;
         assign hit = cfg_wr && (func_reg == fn);
         assign fn_device_id[fn*16+15:fn*16] = did_reg;
         assign fn_class_code[fn*24+23:fn*24] = cc_reg;
         assign fn_subsys_id[fn*16+15:fn*16] = ssid_reg;
         assign fn_int_pin[fn*8+7:fn*8] = pin_reg;
         assign fn_ext_cap[fn] = ext_reg;
         assign fn_pm_cap[fn*16+15:fn*16] = pm_reg;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               did_reg <= 16'h0000;
               cc_reg <= 24'h000000;
               ssid_reg <= 16'h0000;
               pin_reg <= 8'h00;
               ext_reg <= 1'b0;
               pm_reg <= 16'h0000;
            end else if (hit) begin
               // Vendor offsets are absent here on purpose
               case (w_off)
                  `EEZL_CO_DID_LO: did_reg[7:0] <= w_byte;
                  `EEZL_CO_DID_HI: did_reg[15:8] <= w_byte;
                  `EEZL_CO_STAT: ext_reg <= w_byte[4];
                  `EEZL_CO_CC0: cc_reg[7:0] <= w_byte;
                  `EEZL_CO_CC1: cc_reg[15:8] <= w_byte;
                  `EEZL_CO_CC2: cc_reg[23:16] <= w_byte;
                  `EEZL_CO_SSID_LO: ssid_reg[7:0] <= w_byte;
                  `EEZL_CO_SSID_HI: ssid_reg[15:8] <= w_byte;
                  `EEZL_CO_INTPIN: pin_reg <= w_byte;
                  `EEZL_CO_PM_LO: pm_reg[7:0] <= w_byte;
                  `EEZL_CO_PM_HI: pm_reg[15:8] <= w_byte;
                  default: begin
                  end
               endcase
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Control and sticky status; a new overrun beats its own clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `EEZL_CTRL_RST;
         overrun_reg <= 1'b0;
         nomem_reg <= 1'b0;
      end else begin
         if (apb_wr && paddr == `EEZL_OFF_CTRL) begin
            ctrl_reg <= {pwdata[4:1], 1'b0};
         end
         if (overrun) begin
            overrun_reg <= 1'b1;
         end else if (apb_wr && paddr == `EEZL_OFF_STATUS &&
                      pwdata[`EEZL_ST_OVERRUN]) begin
            overrun_reg <= 1'b0;
         end
         if (start) begin
            nomem_reg <= ~mem_present;
         end
      end
   end

   // Read mux; unmapped offsets answer with an error
   always @* begin
      rd_mux = 32'h0000_0000;
      rd_err = 1'b0;
      case (paddr)
         `EEZL_OFF_CTRL: rd_mux = {27'h0, ctrl_reg};
         `EEZL_OFF_STATUS: rd_mux = {28'h0, nomem_reg, overrun_reg,
                                     done_reg, pci_retry};
         `EEZL_OFF_LOCAL_CTRL: rd_mux = local_control_reg;
         `EEZL_OFF_MIO_CFG: rd_mux = multipurpose_io_config;
         `EEZL_OFF_LB_TIM1: rd_mux = local_bus_timing_1;
         `EEZL_OFF_LB_TIM2: rd_mux = local_bus_timing_2;
         `EEZL_OFF_GIR: rd_mux = global_interrupt_reg;
         `EEZL_OFF_IDS: rd_mux = {subsys_vendor_id, vendor_id};
         `EEZL_OFF_F0_ID: rd_mux = {fn_subsys_id[15:0], fn_device_id[15:0]};
         `EEZL_OFF_F1_ID: rd_mux = {fn_subsys_id[31:16],
                                    fn_device_id[31:16]};
         `EEZL_OFF_F0_CLASS: rd_mux = {fn_int_pin[7:0], fn_class_code[23:0]};
         `EEZL_OFF_F1_CLASS: rd_mux = {fn_int_pin[15:8],
                                       fn_class_code[47:24]};
         `EEZL_OFF_F0_MISC: rd_mux = {15'h0, fn_ext_cap[0], fn_pm_cap[15:0]};
         `EEZL_OFF_F1_MISC: rd_mux = {15'h0, fn_ext_cap[1],
                                      fn_pm_cap[31:16]};
         default: rd_err = 1'b1;
      endcase
   end

   // Answer prepared in setup, so every access phase lasts one cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         if (psel && !penable) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= rd_err;
         end
      end
   end

endmodule

`default_nettype wire

// ---- design/eezl_regs.vh ----
/*
 * Constants for the zone configuration loader: APB offsets, register
 * fields, reset values and the offsets of configuration words.
 * Assumes inclusion by bare name from the loader's design files.
 */
`ifndef EEZL_REGS_VH
`define EEZL_REGS_VH

// APB register byte offsets
`define EEZL_OFF_CTRL 8'h00
`define EEZL_OFF_STATUS 8'h04
`define EEZL_OFF_LOCAL_CTRL 8'h08
`define EEZL_OFF_MIO_CFG 8'h0c
`define EEZL_OFF_LB_TIM1 8'h10
`define EEZL_OFF_LB_TIM2 8'h14
`define EEZL_OFF_GIR 8'h18
`define EEZL_OFF_IDS 8'h1c
`define EEZL_OFF_F0_ID 8'h20
`define EEZL_OFF_F1_ID 8'h24
`define EEZL_OFF_F0_CLASS 8'h28
`define EEZL_OFF_F1_CLASS 8'h2c
`define EEZL_OFF_F0_MISC 8'h30
`define EEZL_OFF_F1_MISC 8'h34

// Control register fields
`define EEZL_CTRL_RELOAD 0
`define EEZL_CTRL_ENH 1
`define EEZL_CTRL_ZONE_LO 2
`define EEZL_CTRL_ZONE_HI 4
`define EEZL_CTRL_RST 5'h1c

// Status register fields
`define EEZL_ST_BUSY 0
`define EEZL_ST_DONE 1
`define EEZL_ST_OVERRUN 2
`define EEZL_ST_NOMEM 3

// Configuration word fields
`define EEZL_W_MORE 15
`define EEZL_W_OFF_HI 14
`define EEZL_W_OFF_LO 8
`define EEZL_FH_FN_HI 2

// Reset values of the loaded registers
`define EEZL_RST_LOCAL 32'h0000_0000
`define EEZL_RST_MIO 32'h0000_0000
`define EEZL_RST_TIM1 32'h0000_0000
`define EEZL_RST_TIM2 32'h0000_0000
`define EEZL_RST_GIR 32'h0000_0000
`define EEZL_RST_VID 16'h0000
`define EEZL_RST_SVID 16'h0000

// Local configuration zone offsets
`define EEZL_LO_CTRL 7'h00
`define EEZL_LO_MULTIPURPOSE_PIN_ZERO 7'h04
`define EEZL_LO_MIO1 7'h05
`define EEZL_LO_MIO2 7'h06
`define EEZL_LO_MIO3 7'h07
`define EEZL_LO_T1B1 7'h09
`define EEZL_LO_T1B2 7'h0a
`define EEZL_LO_T1B3 7'h0b
`define EEZL_LO_T2B0 7'h0c
`define EEZL_LO_T2B1 7'h0d
`define EEZL_LO_T2B2 7'h0e
`define EEZL_LO_T2B3 7'h0f
`define EEZL_LO_GIR2 7'h1e
`define EEZL_LO_GIR3 7'h1f

// Identification zone selectors
`define EEZL_ID_VID_LO 7'h00
`define EEZL_ID_VID_HI 7'h01
`define EEZL_ID_SVID_LO 7'h02
`define EEZL_ID_SVID_HI 7'h03

// Configuration space offsets
`define EEZL_CO_DID_LO 7'h02
`define EEZL_CO_DID_HI 7'h03
`define EEZL_CO_STAT 7'h06
`define EEZL_CO_CC0 7'h09
`define EEZL_CO_CC1 7'h0a
`define EEZL_CO_CC2 7'h0b
`define EEZL_CO_SSID_LO 7'h2e
`define EEZL_CO_SSID_HI 7'h2f
`define EEZL_CO_INTPIN 7'h3d
`define EEZL_CO_PM_LO 7'h42
`define EEZL_CO_PM_HI 7'h43

`endif

// ---- design/eezl_word_fetch.v ----
/*
 * Sequential 16-bit word fetcher with overrun detection.
 * Assumes a memory reader that holds ack for one cycle per request.
 */
`default_nettype none

module eezl_word_fetch #(
   parameter ADDR_W = 10
) (
   input wire pclk,
   input wire presetn,
   input wire restart,
   input wire go,
   input wire [ADDR_W:0] mem_size,
   output reg mem_rd_req,
   output reg [ADDR_W-1:0] mem_rd_addr,
   input wire mem_rd_ack,
   input wire [15:0] mem_rd_data,
   output reg word_valid,
   output reg [15:0] word_data,
   output reg overrun
);

   reg [ADDR_W:0] addr_reg;

   ////////////////////////////////////////////////////////////////////
   // Address walk; header word sits at zero, so data starts at one
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_reg <= {{ADDR_W{1'b0}}, 1'b1};
         mem_rd_req <= 1'b0;
         mem_rd_addr <= {ADDR_W{1'b0}};
         word_valid <= 1'b0;
         word_data <= 16'h0000;
         overrun <= 1'b0;
      end else begin
         word_valid <= 1'b0;
         overrun <= 1'b0;
         if (restart) begin
            addr_reg <= {{ADDR_W{1'b0}}, 1'b1};
            mem_rd_req <= 1'b0;
         end else if (go) begin
            // Reading past the end aborts instead of wrapping
            if (addr_reg >= mem_size) begin
               overrun <= 1'b1;
            end else begin
               mem_rd_req <= 1'b1;
               mem_rd_addr <= addr_reg[ADDR_W-1:0];
            end
         end else if (mem_rd_req && mem_rd_ack) begin
            // One word at a time, strictly in order
            mem_rd_req <= 1'b0;
            word_valid <= 1'b1;
            word_data <= mem_rd_data;
            addr_reg <= addr_reg + {{ADDR_W{1'b0}}, 1'b1};
         end
      end
   end

endmodule

`default_nettype wire

// ---- verification/eezl_loader_properties.sv ----
/* Port checker for the zone loader.
   Assumes a bind onto every loader instance, one clock domain. */
`default_nettype none
module eezl_loader_properties #(parameter ADDR_W = 10) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load_start,
   input wire logic mem_present,
   input wire logic [ADDR_W:0] mem_size,
   input wire logic mem_rd_req,
   input wire logic [ADDR_W-1:0] mem_rd_addr,
   input wire logic mem_rd_ack,
   input wire logic pci_retry,
   input wire logic [31:0] local_control_reg,
   input wire logic [31:0] local_bus_timing_2,
   input wire logic [31:0] global_interrupt_reg,
   input wire logic [15:0] vendor_id,
   input wire logic [47:0] fn_class_code
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////
   // Memory handshake and sequencing
   property p_req_drop;
      mem_rd_req && mem_rd_ack |=> !mem_rd_req;
   endproperty
   a_req_drop: assert property (p_req_drop)
      else $error("read request held after its answer");
   property p_req_hold;
      mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr);
   endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("read request dropped or moved before answer");
   property p_addr_seq;
      $rose(mem_rd_req) |->
         mem_rd_addr == 1 || mem_rd_addr == $past(mem_rd_addr, 2) + 1;
   endproperty
   a_addr_seq: assert property (p_addr_seq)
      else $error("word address not sequential");
   property p_in_size;
      mem_rd_req |-> {1'b0, mem_rd_addr} < mem_size;
   endproperty
   a_in_size: assert property (p_in_size)
      else $error("read beyond memory size");
   ////////////////////////////////////////////////////////////////////
   // Bus retry and register stability
   property p_retry_start;
      load_start && mem_present |-> ##[1:2] pci_retry;
   endproperty
   a_retry_start: assert property (p_retry_start)
      else $error("load did not start");
   property p_req_retry;
      mem_rd_req |-> pci_retry;
   endproperty
   a_req_retry: assert property (p_req_retry)
      else $error("memory read while bus not retried");
   property p_regs_idle;
      !pci_retry |=> $stable({local_bus_timing_2, vendor_id, fn_class_code});
   endproperty
   a_regs_idle: assert property (p_regs_idle)
      else $error("loaded register changed outside a load");
   property p_fixed_bits;
      local_control_reg[1:0] == 2'b00 && local_bus_timing_2[19:16] == 4'h0
         && global_interrupt_reg[15:0] == 16'h0000;
   endproperty
   a_fixed_bits: assert property (p_fixed_bits)
      else $error("unloadable bits set");
endmodule
bind eezl_loader eezl_loader_properties #(.ADDR_W(ADDR_W)) u_props (
   .pclk(pclk), .presetn(presetn), .load_start(load_start),
   .mem_present(mem_present), .mem_size(mem_size),
   .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
   .mem_rd_ack(mem_rd_ack), .pci_retry(pci_retry),
   .local_control_reg(local_control_reg),
   .local_bus_timing_2(local_bus_timing_2),
   .global_interrupt_reg(global_interrupt_reg),
   .vendor_id(vendor_id), .fn_class_code(fn_class_code));
`default_nettype wire

// ---- verification/eezl_mem_model.sv ----
/* Word memory model answering the loader's read requests.
   Assumes requests held until ack; dly sets extra wait cycles. */
`default_nettype none
module eezl_mem_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] dly,
   input wire logic mem_rd_req,
   input wire logic [9:0] mem_rd_addr,
   output logic mem_rd_ack,
   output logic [15:0] mem_rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:31];
   logic [3:0] cnt;
   // One word per request; data toggles when not valid, so stale
   // values never look right by chance
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_rd_ack <= 1'b0;
         mem_rd_data <= 16'h0000;
         cnt <= 4'h0;
      end else if (mem_rd_req && !mem_rd_ack && cnt == dly) begin
         mem_rd_ack <= 1'b1;
         mem_rd_data <= mem[mem_rd_addr[4:0]];
         cnt <= 4'h0;
      end else begin
         mem_rd_ack <= 1'b0;
         mem_rd_data <= ~mem_rd_data;
         if (mem_rd_req && !mem_rd_ack)
            cnt <= cnt + 4'h1;
      end
   end
endmodule
`default_nettype wire

// ---- verification/tb_eeprom_zone_config_loader.sv ----
/* Bench for the zone loader: loads memory images, checks registers.
   Assumes the loader, its constants header and the memory model. */
`include "eezl_regs.vh"
`default_nettype none
module tb_eeprom_zone_config_loader;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, load_start = 0, mem_present = 1;
   logic psel = 0, penable = 0, pwrite = 0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd, prdata, lcr, mio, tim2, gir, did, ssid;
   logic [10:0] mem_size = 11'h000;
   logic [3:0] dly = 4'h0;
   logic mem_rd_req, mem_rd_ack, pci_retry, pready, pslverr;
   logic [9:0] mem_rd_addr, last_addr;
   logic [15:0] mem_rd_data, vendor_id, svid, pin;
   logic [31:0] tim1, pm;
   logic [1:0] ext;
   logic [47:0] cls;
   int mismatches = 0, comparisons = 0;
   eezl_loader dut (.pclk(pclk), .presetn(presetn),
      .load_start(load_start), .mem_present(mem_present),
      .mem_size(mem_size), .mem_rd_req(mem_rd_req),
      .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack),
      .mem_rd_data(mem_rd_data), .pci_retry(pci_retry),
      .local_control_reg(lcr), .multipurpose_io_config(mio),
      .local_bus_timing_1(tim1), .local_bus_timing_2(tim2),
      .global_interrupt_reg(gir), .vendor_id(vendor_id),
      .subsys_vendor_id(svid), .fn_device_id(did), .fn_class_code(cls),
      .fn_subsys_id(ssid), .fn_int_pin(pin), .fn_ext_cap(ext),
      .fn_pm_cap(pm),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   eezl_mem_model mm (.pclk(pclk), .presetn(presetn), .dly(dly),
      .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
      .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data));
   always #2 pclk = ~pclk;
   // Last word address actually taken
   always @(posedge pclk)
      if (mem_rd_req && mem_rd_ack)
         last_addr <= mem_rd_addr;
   ////////////////////////////////////////////////////////////////////
   // Shared tasks
   task chk(input logic [47:0] s, input logic [47:0] e);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task test_done;
      if (mismatches == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // APB cycle; no wait-state count assumed, only a bounded wait
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         mismatches++;
         test_done();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wait_idle;
      int n;
      n = 0;
      repeat (4) @(posedge pclk);
      while (pci_retry !== 1'b0 && n < 800) begin
         @(posedge pclk);
         n++;
      end
      if (pci_retry !== 1'b0) begin
         mismatches++;
         test_done();
      end
   endtask
   // Image from word 1 on; content keeps the fixed-zero bits
   task load_img(input logic [15:0] img [$]);
      foreach (img[i])
         mm.mem[i+1] = img[i];
      @(posedge pclk);
      mem_size <= 11'(img.size() + 1);
   endtask
   ////////////////////////////////////////////////////////////////////
   // Scenarios
   task t_skip;
      load_img('{16'h8755, 16'h8933, 16'h0407, 16'h8001, 16'h0b42,
         16'h0000});
      apb(1'b1, `EEZL_OFF_CTRL, 32'h15);
      wait_idle();
      chk(mio, 48'h7);
      chk(cls, 48'h42_0000_000000);
      chk(vendor_id, 48'h0);
      chk(tim1, 48'h3300);
      chk(last_addr, 48'h6);
   endtask
   task t_full;
      load_img('{16'h80fc, 16'h84aa, 16'h87ff, 16'h8ef0, 16'h8fc7,
         16'h1ea5, 16'h8034, 16'h8577, 16'h8356, 16'h0112, 16'h8001,
         16'h82cd, 16'hbd05, 16'h8610, 16'hc211, 16'h80ff, 16'h0b07,
         16'h8000, 16'h2f9a, 16'hffff});
      dly <= 4'h2;
      apb(1'b1, `EEZL_OFF_CTRL, 32'h1e);
      @(posedge pclk);
      load_start <= 1'b1;
      @(posedge pclk);
      load_start <= 1'b0;
      apb(1'b0, `EEZL_OFF_STATUS, 32'h0);
      chk(rd[0], 48'h1);
      wait_idle();
      apb(1'b0, `EEZL_OFF_STATUS, 32'h0);
      chk(rd, 48'h2);
      chk(lcr, 48'hfc);
      chk(mio, 48'he40000aa);
      chk(tim2, 48'hc7f00000);
      chk(gir, 48'ha50000);
      chk(vendor_id, 48'h1234);
      chk(did, 48'hcd0000);
      chk(cls, 48'h07_0000_000000);
      chk(ssid, 48'h9a00);
      chk(svid, 48'h5600);
      chk(pin, 48'h0500);
      chk(ext, 48'h2);
      chk(pm, 48'h110000);
      chk(last_addr, 48'h13);
   endtask
   task t_over;
      load_img('{16'h8010});
      dly <= 4'h0;
      apb(1'b1, `EEZL_OFF_CTRL, 32'h1d);
      wait_idle();
      apb(1'b0, `EEZL_OFF_STATUS, 32'h0);
      chk(rd & 32'h5, 48'h4);
      chk(lcr, 48'h10);
      apb(1'b1, `EEZL_OFF_STATUS, 32'h4);
      apb(1'b0, `EEZL_OFF_STATUS, 32'h0);
      chk(rd[2], 48'h0);
   endtask
   task t_nomem;
      mem_present <= 1'b0;
      @(posedge pclk);
      load_start <= 1'b1;
      @(posedge pclk);
      load_start <= 1'b0;
      mem_present <= 1'b1;
      wait_idle();
      apb(1'b0, `EEZL_OFF_STATUS, 32'h0);
      chk(rd[3], 48'h1);
      apb(1'b0, 8'hfc, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
   endtask
   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `EEZL_OFF_CTRL, 32'h0);
      chk(rd, 48'h1c);
      t_skip();
      t_full();
      t_over();
      t_nomem();
      test_done();
   end
endmodule
`default_nettype wire
